//--- pmr_regs.sv
// Power-good mask and auxiliary rail control registers behind an I2C slave port
// How it works
// - Output-three mask bits 7..4 mask control pins five, four, two, one.
// - Output-three mask bit 3 masks termination regulator power-good.
// - Output-three mask bit 2 masks the shared auxiliary rail power-good.
// - Output-three mask bit 1 masks the first load switch power-good.
// - Output-three mask bit 0 masks the third auxiliary LDO power-good.
// - Sleep mask bits 7..4 mask pins three, six from outputs one, four.
// - Sleep mask bits 3..0 mask pins three, six from outputs two, three.
// - A cleared sleep mask bit includes that pin in the tree.
// - Termination discharge bit 4 enables the 100 ohm discharge path.
// - Config bit clear: rail drops during emergency shutdown for programmed time.
// - Config bit set: rail follows only its enable bit.
// - LDO in sequence with unmerged switches steers control to second switch.
// - Auxiliary bits 4:1 set the auxiliary LDO voltage code.
// - Auxiliary bit 0 enables the selected auxiliary rail.
`timescale 1ns/1ns
module pmr_regs
  import pmr_pkg::*;
#(
  parameter int unsigned MS_CYC   = PMR_MS_CYC,
  parameter logic [6:0]  DEV_ADDR = PMR_I2C_ADDR
) (
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         scl_pin,
  input  wire logic         sda_pin_in,
  output logic              sda_pin_out,
  output logic              sda_pin_oe,
  input  wire logic [5:0]   control_pin,
  input  wire pmr_otp_t     otp,
  input  wire logic [3:0]   base_pg,
  input  wire pmr_rail_pg_t rail_pg,
  input  wire logic         emergency_shutdown,
  output logic [3:0]        power_good,
  output logic              termination_discharge_sel,
  output logic [1:0]        aux_discharge_resistance,
  output logic [3:0]        aux_voltage_code,
  output logic              aux_ldo_first_en,
  output logic              load_switch_second_en
);

  if (MS_CYC < 1 || MS_CYC > 40_000) begin : g_chk
    $error("MS_CYC out of range");
  end

  // ==========================================================================
  // Pin synchronisers: control pins, then scl, then sda
  logic [7:0] pin_raw;
  logic [7:0] pin_s1;
  logic [7:0] pin_s2;
  logic [7:0] pin_s3;
  logic [7:0] pin_f;

  assign pin_raw = {sda_pin_in, scl_pin, control_pin};

  always_ff @(posedge sys_clk) begin
    pin_s1 <= pin_raw;
    pin_s2 <= pin_s1;
    pin_s3 <= pin_s2;
  end

  // A change counts only once the last two stages agree, a cheap glitch filter
  for (genvar i = 0; i < 8; i++) begin : g_filt
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        pin_f[i] <= 1'b1;
      end else if (pin_s2[i] == pin_s3[i]) begin
        pin_f[i] <= pin_s3[i];
      end
    end
  end

  logic [5:0] ctl_f;
  logic       scl_f;
  logic       sda_f;
  logic       scl_d;
  logic       sda_d;

  assign ctl_f = pin_f[5:0];
  assign scl_f = pin_f[6];
  assign sda_f = pin_f[7];

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_f;
      sda_d <= sda_f;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;

  assign scl_rise = scl_f & ~scl_d;
  assign scl_fall = ~scl_f & scl_d;
  assign start_c  = scl_f & scl_d & sda_d & ~sda_f;
  assign stop_c   = scl_f & scl_d & ~sda_d & sda_f;

  // ==========================================================================
  // Registers
  logic [7:0] out3_mask2;
  logic [7:0] sleep_mask;
  logic [7:0] term_dis;
  logic [7:0] aux_ctrl;
  logic       wr_stb;
  logic [7:0] wr_ptr;
  logic [7:0] wr_data;

  // Reserved discharge bits are stored as written; software keeps them matched
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      out3_mask2 <= otp.out3_mask2;
      sleep_mask <= otp.sleep_mask;
      term_dis   <= otp.term_dis;
      aux_ctrl   <= otp.aux_ctrl;
    end else if (wr_stb) begin
      case (wr_ptr)
        PMR_OFF_OUT3_MASK2: out3_mask2 <= wr_data;
        PMR_OFF_SLEEP_MASK: sleep_mask <= wr_data;
        PMR_OFF_TERM_DIS:   term_dis   <= wr_data;
        PMR_OFF_AUX_CTRL:   aux_ctrl   <= wr_data;
        default: ;
      endcase
    end
  end

  // Unmapped offsets read as zero
  function automatic logic [7:0] rd_value(input logic [7:0] a);
    case (a)
      PMR_OFF_OUT3_MASK2: rd_value = out3_mask2;
      PMR_OFF_SLEEP_MASK: rd_value = sleep_mask;
      PMR_OFF_TERM_DIS:   rd_value = term_dis;
      PMR_OFF_AUX_CTRL:   rd_value = aux_ctrl;
      default:            rd_value = 8'h00;
    endcase
  endfunction

  // ==========================================================================
  // I2C slave: pointer byte, then auto-incrementing data bytes
  typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_TXACK} pmr_i2c_st_t;
  typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA} pmr_kind_t;

  pmr_i2c_st_t st;
  pmr_kind_t   kind;
  logic [3:0]  bit_cnt;
  logic [7:0]  shreg;
  logic [7:0]  ptr;
  logic        rw;
  logic        nack;
  logic        sda_drv;
  logic [7:0]  rd_byte;

  assign rd_byte     = rd_value(ptr);
  assign sda_pin_out = 1'b0;
  assign sda_pin_oe  = sda_drv;

  always_ff @(posedge sys_clk) begin
    wr_stb <= 1'b0;
    if (sys_rst) begin
      st      <= I_IDLE;
      kind    <= K_ADDR;
      bit_cnt <= 4'h0;
      shreg   <= 8'h00;
      ptr     <= 8'h00;
      rw      <= 1'b0;
      nack    <= 1'b0;
      sda_drv <= 1'b0;
      wr_ptr  <= 8'h00;
      wr_data <= 8'h00;
    end else if (start_c) begin
      st      <= I_RX;
      kind    <= K_ADDR;
      bit_cnt <= 4'h0;
      sda_drv <= 1'b0;
    end else if (stop_c) begin
      st      <= I_IDLE;
      sda_drv <= 1'b0;
    end else begin
      unique case (st)
        I_IDLE: ;
        I_RX: begin
          if (scl_rise) begin
            shreg   <= {shreg[6:0], sda_f};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            st      <= I_ACK;
            sda_drv <= 1'b1;
            unique case (kind)
              K_ADDR: begin
                if (shreg[7:1] != DEV_ADDR) begin
                  st      <= I_IDLE;
                  sda_drv <= 1'b0;
                end else begin
                  rw   <= shreg[0];
                  kind <= K_PTR;
                end
              end
              K_PTR: begin
                ptr  <= shreg;
                kind <= K_DATA;
              end
              K_DATA: begin
                wr_stb  <= 1'b1;
                wr_ptr  <= ptr;
                wr_data <= shreg;
                ptr     <= ptr + 8'h01;
              end
            endcase
          end
        end
        I_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (rw) begin
              st      <= I_TX;
              shreg   <= rd_byte;
              ptr     <= ptr + 8'h01;
              sda_drv <= ~rd_byte[7];
            end else begin
              st      <= I_RX;
              sda_drv <= 1'b0;
            end
          end
        end
        I_TX: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h7) begin
              st      <= I_TXACK;
              sda_drv <= 1'b0;
            end else begin
              shreg   <= {shreg[6:0], 1'b0};
              sda_drv <= ~shreg[6];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        I_TXACK: begin
          if (scl_rise) begin
            nack <= sda_f;
          end else if (scl_fall) begin
            if (nack) begin
              st <= I_IDLE;
            end else begin
              st      <= I_TX;
              bit_cnt <= 4'h0;
              shreg   <= rd_byte;
              ptr     <= ptr + 8'h01;
              sda_drv <= ~rd_byte[7];
            end
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Power-good trees
  function automatic logic sleep_ok(input logic p3, input logic p6, input logic ma, input logic mb);
    sleep_ok = (p3 | ma) & (p6 | mb);
  endfunction

  logic [3:0] next_pg;

  always_comb begin
    next_pg[0] = base_pg[0] & sleep_ok(ctl_f[2], ctl_f[5], sleep_mask[PMR_SL_O1_A], sleep_mask[PMR_SL_O1_B]);
    next_pg[3] = base_pg[3] & sleep_ok(ctl_f[2], ctl_f[5], sleep_mask[PMR_SL_O4_A], sleep_mask[PMR_SL_O4_B]);
    next_pg[1] = base_pg[1] & sleep_ok(ctl_f[2], ctl_f[5], sleep_mask[PMR_SL_O2_A], sleep_mask[PMR_SL_O2_B]);
    next_pg[2] = base_pg[2] & sleep_ok(ctl_f[2], ctl_f[5], sleep_mask[PMR_SL_O3_A], sleep_mask[PMR_SL_O3_B])
               & (ctl_f[4] | out3_mask2[PMR_M2_PIN5]) & (ctl_f[3] | out3_mask2[PMR_M2_PIN4])
               & (ctl_f[1] | out3_mask2[PMR_M2_PIN2]) & (ctl_f[0] | out3_mask2[PMR_M2_PIN1])
               & (rail_pg.term | out3_mask2[PMR_M2_TERM])
               & (rail_pg.shared_aux | out3_mask2[PMR_M2_SHARED])
               & (rail_pg.first_sw | out3_mask2[PMR_M2_FIRST_SW])
               & (rail_pg.third_ldo | out3_mask2[PMR_M2_THIRD]);
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      power_good <= 4'h0;
    end else begin
      power_good <= next_pg;
    end
  end

  // ==========================================================================
  // Emergency shutdown hold-off and auxiliary rail control
  logic [31:0] shdn_cnt;
  logic [31:0] shdn_len;
  logic        shdn_active;
  logic        steer_sw2;
  logic        rail_on;

  always_comb begin
    unique case (otp.shdn_sel)
      2'b00: shdn_len = 32'(PMR_SHDN_MS_0 * MS_CYC);
      2'b01: shdn_len = 32'(PMR_SHDN_MS_1 * MS_CYC);
      2'b10: shdn_len = 32'(PMR_SHDN_MS_2 * MS_CYC);
      2'b11: shdn_len = 32'(PMR_SHDN_MS_3 * MS_CYC);
    endcase
  end

  // The off time is counted from the fall of the shutdown request
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      shdn_cnt <= 32'h0;
    end else if (emergency_shutdown) begin
      shdn_cnt <= shdn_len;
    end else if (shdn_cnt != 32'h0) begin
      shdn_cnt <= shdn_cnt - 32'h1;
    end
  end

  assign shdn_active = emergency_shutdown | (shdn_cnt != 32'h0);
  assign steer_sw2   = otp.aux_is_sw2 | (otp.ldo_in_seq & ~otp.sw_merged);
  assign rail_on     = aux_ctrl[PMR_AUX_EN] & (aux_ctrl[PMR_AUX_SHDN_CFG] | ~shdn_active);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      aux_ldo_first_en      <= 1'b0;
      load_switch_second_en <= 1'b0;
    end else begin
      aux_ldo_first_en      <= rail_on & ~steer_sw2;
      load_switch_second_en <= rail_on & steer_sw2;
    end
  end

  assign termination_discharge_sel = term_dis[PMR_TERM_DIS_BIT];
  assign aux_discharge_resistance  = aux_ctrl[PMR_AUX_DIS_HI:PMR_AUX_DIS_LO];
  assign aux_voltage_code          = aux_ctrl[PMR_AUX_VC_HI:PMR_AUX_VC_LO];

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  term_tree_a: assert property (!out3_mask2[PMR_M2_TERM] && !rail_pg.term |=> !power_good[2])
    else $error("termination pg not in tree");
  pin_five_a: assert property (!out3_mask2[PMR_M2_PIN5] && !ctl_f[4] |=> !power_good[2])
    else $error("pin five not in tree");
  shared_aux_a: assert property (!out3_mask2[PMR_M2_SHARED] && !rail_pg.shared_aux |=> !power_good[2])
    else $error("shared aux pg not in tree");
  first_sw_a: assert property (!out3_mask2[PMR_M2_FIRST_SW] && !rail_pg.first_sw |=> !power_good[2])
    else $error("first switch pg not in tree");
  third_ldo_a: assert property (!out3_mask2[PMR_M2_THIRD] && !rail_pg.third_ldo |=> !power_good[2])
    else $error("third ldo pg not in tree");
  masked_ignore_a: assert property ((&out3_mask2) && (&sleep_mask) && base_pg == 4'hF |=> power_good == 4'hF)
    else $error("fully masked tree not good");
  out1_sleep_a: assert property (!sleep_mask[PMR_SL_O1_A] && !ctl_f[2] |=> !power_good[0])
    else $error("pin three not in output one tree");
  out2_sleep_a: assert property (!sleep_mask[PMR_SL_O2_B] && !ctl_f[5] |=> !power_good[1])
    else $error("pin six not in output two tree");
  term_dis_a: assert property (wr_stb && wr_ptr == PMR_OFF_TERM_DIS |=> termination_discharge_sel == $past(wr_data[PMR_TERM_DIS_BIT]))
    else $error("termination discharge not written");
  shdn_off_a: assert property (emergency_shutdown && !aux_ctrl[PMR_AUX_SHDN_CFG] |=> !(aux_ldo_first_en | load_switch_second_en))
    else $error("rail on during shutdown");
  shdn_bypass_a: assert property (aux_ctrl[PMR_AUX_SHDN_CFG] |=> (aux_ldo_first_en | load_switch_second_en) == $past(aux_ctrl[0]))
    else $error("rail not following enable");

  write_cov_c: cover property (wr_stb && wr_ptr == PMR_OFF_AUX_CTRL);
  read_cov_c: cover property (st == I_TX && scl_fall);
  shdn_cov_c: cover property ($fell(emergency_shutdown) && shdn_cnt != 32'h0);

endmodule

//--- pmr_pkg.sv
// Package: register map, field positions, timing and carrier types of the power-good mask block
package pmr_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] PMR_OFF_OUT3_MASK2 = 8'hAB;
  localparam logic [7:0] PMR_OFF_SLEEP_MASK = 8'hAC;
  localparam logic [7:0] PMR_OFF_TERM_DIS   = 8'hAD;
  localparam logic [7:0] PMR_OFF_AUX_CTRL   = 8'hAE;

  // ==========================================================================
  // Field positions, output-three mask register
  localparam int PMR_M2_PIN5     = 7;
  localparam int PMR_M2_PIN4     = 6;
  localparam int PMR_M2_PIN2     = 5;
  localparam int PMR_M2_PIN1     = 4;
  localparam int PMR_M2_TERM     = 3;
  localparam int PMR_M2_SHARED   = 2;
  localparam int PMR_M2_FIRST_SW = 1;
  localparam int PMR_M2_THIRD    = 0;

  // Field positions, sleep-pin mask register (A = pin three, B = pin six)
  localparam int PMR_SL_O1_A = 7;
  localparam int PMR_SL_O1_B = 6;
  localparam int PMR_SL_O4_A = 5;
  localparam int PMR_SL_O4_B = 4;
  localparam int PMR_SL_O2_A = 3;
  localparam int PMR_SL_O2_B = 2;
  localparam int PMR_SL_O3_A = 1;
  localparam int PMR_SL_O3_B = 0;

  // Field positions, discharge and auxiliary control
  localparam int PMR_TERM_DIS_BIT = 4;
  localparam int PMR_AUX_DIS_HI   = 7;
  localparam int PMR_AUX_DIS_LO   = 6;
  localparam int PMR_AUX_SHDN_CFG = 5;
  localparam int PMR_AUX_VC_HI    = 4;
  localparam int PMR_AUX_VC_LO    = 1;
  localparam int PMR_AUX_EN       = 0;

  // ==========================================================================
  // Timing
  localparam int unsigned PMR_CLK_HZ    = 25_000_000;
  localparam int unsigned PMR_SHDN_MS_0 = 1;
  localparam int unsigned PMR_SHDN_MS_1 = 5;
  localparam int unsigned PMR_SHDN_MS_2 = 10;
  localparam int unsigned PMR_SHDN_MS_3 = 100;
  localparam int unsigned PMR_MS_CYC    = PMR_CLK_HZ / 1000;

  // Slave address, value arbitrary
  localparam logic [6:0] PMR_I2C_ADDR = 7'h5E;

  // ==========================================================================
  // Carrier types
  typedef struct packed {
    logic [7:0] out3_mask2;
    logic [7:0] sleep_mask;
    logic [7:0] term_dis;
    logic [7:0] aux_ctrl;
    logic [1:0] shdn_sel;
    logic       aux_is_sw2;
    logic       ldo_in_seq;
    logic       sw_merged;
  } pmr_otp_t;

  typedef struct packed {
    logic term;
    logic shared_aux;
    logic first_sw;
    logic third_ldo;
  } pmr_rail_pg_t;

endpackage

//--- pmr_rail_model.sv
// Far-side model: regulator power-good levels and control pins, with a selectable lag
`timescale 1ns/1ns
module pmr_rail_model
  import pmr_pkg::*;
(
  input  wire logic   sys_clk,
  input  wire logic [9:0] want,
  input  wire logic   slow,
  output logic [5:0]  control_pin,
  output pmr_rail_pg_t rail_pg
);
  // ==========================================================================
  // Lag line
  // Slow mode holds every change back eight cycles, as a ramping rail would
  logic [9:0] lag [8];

  always_ff @(posedge sys_clk) begin
    lag[0] <= want;
    for (int i = 1; i < 8; i++) begin
      lag[i] <= lag[i-1];
    end
  end

  assign {rail_pg, control_pin} = slow ? lag[7] : want;
endmodule

//--- test_power_good_mask_and_rail_ctrl_regs.sv
// Self-checking bench of the power-good mask and auxiliary rail registers
`timescale 1ns/1ns
module test_power_good_mask_and_rail_ctrl_regs
  import pmr_pkg::*;
;
  localparam int         MS  = 10;
  localparam logic [6:0] ADR = 7'h5E;
  logic         sys_clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         scl     = 1'b1;
  logic         sda_m   = 1'b1;
  logic         sda_oe;
  logic         sda_out;
  logic [9:0]   want    = 10'h3FF;
  logic         slow    = 1'b0;
  logic         esd     = 1'b0;
  logic [3:0]   base_pg = 4'hF;
  pmr_otp_t     otp     = '{8'h5A, 8'hC3, 8'h50, 8'h96, 2'h0, 1'b0, 1'b0, 1'b0};
  logic [5:0]   ctl;
  pmr_rail_pg_t rail;
  logic [3:0]   pg;
  logic         term_dis;
  logic         ldo_en;
  logic         sw2_en;
  logic [1:0]   dis;
  logic [3:0]   vc;
  int           miscompares = 0;
  int           num_checks  = 0;
  wire          sda = sda_m & (sda_oe ? sda_out : 1'b1);

  always #20 sys_clk = ~sys_clk;

  pmr_rail_model u_far (.sys_clk(sys_clk), .want(want), .slow(slow), .control_pin(ctl), .rail_pg(rail));

  pmr_regs #(.MS_CYC(MS), .DEV_ADDR(ADR)) u_dut (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .scl_pin(scl), .sda_pin_in(sda), .sda_pin_out(sda_out),
    .sda_pin_oe(sda_oe), .control_pin(ctl), .otp(otp), .base_pg(base_pg), .rail_pg(rail),
    .emergency_shutdown(esd), .power_good(pg), .termination_discharge_sel(term_dis),
    .aux_discharge_resistance(dis), .aux_voltage_code(vc), .aux_ldo_first_en(ldo_en),
    .load_switch_second_en(sw2_en));

  // ==========================================================================
  // Helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // Data moves two cycles after the clock falls, so the filters never see it cross an edge
  task automatic bitx(input logic b, output logic r);
    sda_m = b;
    cyc(10);
    scl = 1'b1;
    cyc(5);
    r = sda;
    cyc(5);
    scl = 1'b0;
    cyc(2);
  endtask

  task automatic start();
    sda_m = 1'b1;
    cyc(10);
    scl = 1'b1;
    cyc(10);
    sda_m = 1'b0;
    cyc(10);
    scl = 1'b0;
    cyc(2);
  endtask

  task automatic stop();
    sda_m = 1'b0;
    cyc(10);
    scl = 1'b1;
    cyc(10);
    sda_m = 1'b1;
    cyc(10);
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], r);
    end
    bitx(1'b1, r);
    ack = ~r;
  endtask

  task automatic wr(input logic [7:0] off, input logic [7:0] d);
    logic a0, a1, a2;
    start();
    wbyte({ADR, 1'b0}, a0);
    wbyte(off, a1);
    wbyte(d, a2);
    stop();
    check(8'(a0 & a1 & a2), 8'h01, "write acknowledge");
  endtask

  task automatic rc(input logic [7:0] off, input logic [7:0] exp);
    logic a;
    logic r;
    logic [7:0] d;
    start();
    wbyte({ADR, 1'b0}, a);
    wbyte(off, a);
    start();
    wbyte({ADR, 1'b1}, a);
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, d[i]);
    end
    bitx(1'b1, r);
    stop();
    check(d, exp, "register read");
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    logic a;
    rc(PMR_OFF_OUT3_MASK2, otp.out3_mask2);
    rc(PMR_OFF_SLEEP_MASK, otp.sleep_mask);
    rc(PMR_OFF_TERM_DIS, otp.term_dis);
    rc(PMR_OFF_AUX_CTRL, otp.aux_ctrl);
    rc(8'hB0, 8'h00);
    check(8'(dis), 8'(otp.aux_ctrl[7:6]), "discharge");
    check(8'(vc), 8'(otp.aux_ctrl[4:1]), "voltage code");
    check(8'(term_dis), 8'(otp.term_dis[4]), "termination discharge");
    check(8'(ldo_en), 8'h00, "rail enable");
    start();
    wbyte({ADR ^ 7'h01, 1'b0}, a);
    stop();
    check(8'(a), 8'h00, "foreign address");
    $display("test reset values done");
  endtask

  task automatic t_fields();
    logic [7:0] v;
    for (int k = 0; k < 4; k++) begin
      v = {2'(k), 1'b1, 4'(k * 5 + 1), 1'(k)};
      wr(PMR_OFF_AUX_CTRL, v);
      rc(PMR_OFF_AUX_CTRL, v);
      check(8'(dis), 8'(k), "discharge");
      check(8'(vc), 8'(v[4:1]), "voltage code");
      check(8'(ldo_en), 8'(k & 1), "rail enable");
      wr(PMR_OFF_TERM_DIS, {3'b010, 1'(k), 4'h0});
      check(8'(term_dis), 8'(k & 1), "termination discharge");
    end
    $display("test register fields done");
  endtask

  task automatic mask_case(input logic [7:0] off, input int b, input int src, input int o);
    wr(off, ~(8'h01 << b));
    cyc(30);
    check(8'(pg[o]), 8'h01, "tree all good");
    want[src] = 1'b0;
    cyc(30);
    check(8'(pg[o]), 8'h00, "contributor included");
    wr(off, 8'h01 << b);
    cyc(30);
    check(8'(pg[o]), 8'h01, "contributor masked");
    want[src] = 1'b1;
  endtask

  task automatic t_trees();
    int ab_src [8] = '{6, 7, 8, 9, 0, 1, 3, 4};
    int sl_out [8] = '{2, 2, 1, 1, 3, 3, 0, 0};
    for (int b = 0; b < 8; b++) begin
      mask_case(PMR_OFF_OUT3_MASK2, b, ab_src[b], 2);
    end
    slow = 1'b1;
    for (int b = 0; b < 8; b++) begin
      mask_case(PMR_OFF_SLEEP_MASK, b, b[0] ? 2 : 5, sl_out[b]);
    end
    slow = 1'b0;
    for (int k = 0; k < 4; k++) begin
      base_pg[k] = 1'b0;
      cyc(5);
      check(8'(pg[k]), 8'h00, "rest of tree");
      base_pg[k] = 1'b1;
    end
    wr(PMR_OFF_OUT3_MASK2, 8'hFF);
    wr(PMR_OFF_SLEEP_MASK, 8'hFF);
    want = 10'h000;
    cyc(30);
    check(8'(pg), 8'h0F, "all contributors masked");
    want = 10'h3FF;
    cyc(30);
    $display("test power-good trees done");
  endtask

  task automatic reboot();
    sys_rst = 1'b1;
    cyc(4);
    sys_rst = 1'b0;
    cyc(6);
  endtask

  task automatic t_shdn();
    int n;
    int ms [4] = '{1, 5, 10, 100};
    for (int s = 0; s < 4; s++) begin
      otp.shdn_sel = 2'(s);
      reboot();
      wr(PMR_OFF_AUX_CTRL, 8'h01);
      check(8'(ldo_en), 8'h01, "rail on");
      esd = 1'b1;
      cyc(3);
      check(8'(ldo_en), 8'h00, "rail off in shutdown");
      esd = 1'b0;
      n = 0;
      while (ldo_en !== 1'b1 && n < 1100) begin
        cyc(1);
        n++;
      end
      check(8'(n >= ms[s] * MS - 3 && n <= ms[s] * MS + 3), 8'h01, "shutdown length");
    end
    wr(PMR_OFF_AUX_CTRL, 8'h21);
    esd = 1'b1;
    cyc(3);
    check(8'(ldo_en), 8'h01, "rail ignores shutdown");
    esd = 1'b0;
    wr(PMR_OFF_AUX_CTRL, 8'h20);
    check(8'(ldo_en), 8'h00, "rail off by enable");
    otp.shdn_sel = 2'h0;
    otp.ldo_in_seq = 1'b1;
    reboot();
    wr(PMR_OFF_AUX_CTRL, 8'h01);
    check(8'({sw2_en, ldo_en}), 8'h02, "steered to second switch");
    esd = 1'b1;
    cyc(3);
    check(8'(sw2_en), 8'h00, "second switch in shutdown");
    esd = 1'b0;
    cyc(MS + 5);
    check(8'(sw2_en), 8'h01, "second switch back on");
    otp.sw_merged = 1'b1;
    reboot();
    wr(PMR_OFF_AUX_CTRL, 8'h01);
    check(8'({sw2_en, ldo_en}), 8'h01, "merged switches keep the LDO");
    otp.aux_is_sw2 = 1'b1;
    reboot();
    wr(PMR_OFF_AUX_CTRL, 8'h01);
    check(8'({sw2_en, ldo_en}), 8'h02, "rail built as second switch");
    otp.aux_is_sw2 = 1'b0;
    $display("test emergency shutdown done");
  endtask

  // ==========================================================================
  // Run control
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    cyc(3);
    sys_rst = 1'b0;
    cyc(6);
    t_reset();
    t_fields();
    t_trees();
    t_shdn();
    print_verdict();
  end

  // About twice the expected run length
  initial begin
    #4_000_000;
    miscompares++;
    print_verdict();
  end
endmodule
